//--- ipc_defs.vh
// Purpose: Shared constants for the interrupt priority controller
// Assumes: APB byte addressing, 32-bit data words
// Notes:   Printed offsets are register indexes; byte address is 4x
`ifndef IPC_DEFS_VH
`define IPC_DEFS_VH

// ****************************************
// Register indexes and byte addresses
// ****************************************
`define IPC_IDX_EXT_ENABLE_ONE   12'h09c
`define IPC_IDX_PRIO_HIGH        12'h0b7
`define IPC_IDX_PRIO_LOW         12'h0b8
`define IPC_ADDR_EXT_ENABLE_ONE  12'h270
`define IPC_ADDR_PRIO_HIGH       12'h2dc
`define IPC_ADDR_PRIO_LOW        12'h2e0
`define IPC_ADDR_SRC_ENABLE      12'h000
`define IPC_ADDR_EXT_PRIO        12'h004
`define IPC_ADDR_TRIGGER         12'h008
`define IPC_ADDR_FLAGS           12'h00c
`define IPC_ADDR_PIN_FLAGS       12'h010
`define IPC_ADDR_STATUS          12'h014

// ****************************************
// Field positions and reset values
// ****************************************
`define IPC_GLOBAL_ENABLE_BIT    31
`define IPC_EXTENDED_INTERRUPT_ENABLE_ONE_WKT_BIT         2
`define IPC_EXTENDED_INTERRUPT_ENABLE_ONE_T3_BIT          1
`define IPC_EXTENDED_INTERRUPT_ENABLE_ONE_S1_BIT          0
`define IPC_REG8_RESET           8'h00
`define IPC_REG32_RESET          32'h00000000

// ****************************************
// Timing and source count
// ****************************************
`define IPC_CALL_CYCLES          3'h4
`define IPC_NUM_SOURCES          18

`endif

//--- ipc_interrupt_priority_controller.v
// Purpose: Interrupt priority, nesting, vector and wake-up decision logic
// Assumes: Core pulses poll_ok on an instruction's last cycle, reti on RETI
// Notes:   APB slave, zero wait states, all state frozen while ce is low
//
// How it works
// - Four priority levels, zero lowest
// - Level equals high bit then low bit
// - Preempt only by strictly higher level
// - Return resumes preempted handler, then main
// - Lowest level starts only when idle
// - Highest level wins, ties by order
// - Fixed natural order of eighteen sources
// - Fixed vectors 0003H to 008BH, 8 apart
// - Only six sources wake from power-down
// - Edge external flag clears on entry
// - Level external flag equals inverted pin
// - Timer 0/1/3 auto-clear, timer 2 not
// - Level pin channel flag follows input
// - Extended enable bits for wakeup, timer 3
// - Extended enable bit 0 for serial 1
// - Low priority register bit assignment
// - High priority register, same assignment
// - Global enable off blocks, keeps pending
// - Fresh polling each cycle, no memory
// - Call lasts four cycles, five latency
//
// The APB slave port was left to the implementer.
`include "ipc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ipc_interrupt_priority_controller #(
  parameter NSRC = `IPC_NUM_SOURCES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext0_pin_n,
  input  wire        ext1_pin_n,
  input  wire        timer0_overflow_set,
  input  wire        timer1_overflow_set,
  input  wire        timer2_event_set,
  input  wire        timer3_overflow_set,
  input  wire [7:0]  pin_channel_in,
  input  wire        brownout_req,
  input  wire        watchdog_req,
  input  wire        i2c_req,
  input  wire        adc_req,
  input  wire        serial0_req,
  input  wire        fault_brake_req,
  input  wire        spi_req,
  input  wire        capture_req,
  input  wire        pwm_req,
  input  wire        serial1_transmit_flag,
  input  wire        serial1_receive_flag,
  input  wire        wakeup_timer_flag,
  input  wire        poll_ok,
  input  wire        reti,
  output reg         irq_call,
  output reg         irq_call_busy,
  output reg  [15:0] irq_vector,
  output reg  [1:0]  irq_level,
  output reg         wake_request
);

  // ****************************************
  // Registers and flags
  // ****************************************
  reg  [7:0]  extended_interrupt_enable_one;
  reg  [7:0]  interrupt_priority_high_bits;
  reg  [7:0]  interrupt_priority_low_bits;
  reg  [31:0] src_enable;
  reg  [31:0] ext_prio;
  reg  [15:0] trigger_cfg;
  reg         external0_request_flag;
  reg         external1_request_flag;
  reg         timer0_overflow_flag;
  reg         timer1_overflow_flag;
  reg         timer2_event_flag;
  reg         timer3_overflow_flag;
  reg  [7:0]  pin_channel_flag;
  reg         ext0_pin_q;
  reg         ext1_pin_q;
  reg  [7:0]  pin_in_q;
  reg  [3:0]  in_service;
  reg  [2:0]  call_cnt;
  reg  [4:0]  last_src;

  wire        wr = psel & penable & pready & pwrite;
  wire        global_irq_enable = src_enable[`IPC_GLOBAL_ENABLE_BIT];
  wire        ext0_fall = ext0_pin_q & ~ext0_pin_n;
  wire        ext1_fall = ext1_pin_q & ~ext1_pin_n;
  wire        it0_edge = trigger_cfg[0];
  wire        it1_edge = trigger_cfg[1];
  wire [7:0]  pin_level_mode = trigger_cfg[15:8];
  wire        wakeup_timer_irq_enable =
    extended_interrupt_enable_one[`IPC_EXTENDED_INTERRUPT_ENABLE_ONE_WKT_BIT];
  wire        timer3_irq_enable =
    extended_interrupt_enable_one[`IPC_EXTENDED_INTERRUPT_ENABLE_ONE_T3_BIT];
  wire        serial1_irq_enable =
    extended_interrupt_enable_one[`IPC_EXTENDED_INTERRUPT_ENABLE_ONE_S1_BIT];

  // ****************************************
  // Request, enable and level vectors
  // ****************************************
  // Index is natural order minus one: 0 services before 17
  wire [NSRC-1:0] req = {wakeup_timer_flag, timer3_overflow_flag,
    serial1_transmit_flag | serial1_receive_flag, pwm_req, capture_req,
    timer2_event_flag, spi_req, fault_brake_req, serial0_req,
    timer1_overflow_flag, |pin_channel_flag, external1_request_flag,
    adc_req, i2c_req, timer0_overflow_flag, watchdog_req, brownout_req,
    external0_request_flag};
  wire [NSRC-1:0] enable = {wakeup_timer_irq_enable, timer3_irq_enable,
    serial1_irq_enable, src_enable[14:0]};
  wire [7:0] lo = interrupt_priority_low_bits;
  wire [7:0] hi = interrupt_priority_high_bits;
  wire [NSRC-1:0] prio_lo = {ext_prio[10:8], ext_prio[7:3], lo[4], lo[3],
    ext_prio[2], lo[2], lo[6], ext_prio[1], lo[1], ext_prio[0], lo[5],
    lo[0]};
  wire [NSRC-1:0] prio_hi = {ext_prio[26:24], ext_prio[23:19], hi[4],
    hi[3], ext_prio[18], hi[2], hi[6], ext_prio[17], hi[1], ext_prio[16],
    hi[5], hi[0]};
  // Blocked requests are not latched; recomputed every cycle
  wire [NSRC-1:0] pending = req & enable &
    {NSRC{global_irq_enable}};
  wire [NSRC-1:0] wake_mask = 18'h200c7;

  // ****************************************
  // Arbitration
  // ****************************************
  reg        win_valid;
  reg  [4:0] win_src;
  reg  [1:0] win_lvl;
  reg  [1:0] cur_lvl;
  reg        cur_busy;
  integer    i;
  integer    j;

  always @* begin
    win_valid = 1'b0;
    win_src = 5'h00;
    win_lvl = 2'h0;
    // Downward scan so equal levels end on the lowest index
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (pending[i] &&
          (!win_valid || {prio_hi[i], prio_lo[i]} >= win_lvl)) begin
        win_valid = 1'b1;
        win_src = i[4:0];
        win_lvl = {prio_hi[i], prio_lo[i]};
      end
    end
  end

  always @* begin
    cur_busy = |in_service;
    cur_lvl = 2'h0;
    if (in_service[3]) begin
      cur_lvl = 2'h3;
    end else if (in_service[2]) begin
      cur_lvl = 2'h2;
    end else if (in_service[1]) begin
      cur_lvl = 2'h1;
    end
  end

  // Level 0 can never exceed a running level, so it needs idle
  wire take = ce & poll_ok & ~reti & win_valid & (call_cnt == 3'h0) &
    (!cur_busy || win_lvl > cur_lvl);

  function [15:0] vector_of;
    input [4:0] s;
    begin
      case (s)
        5'd0:    vector_of = 16'h0003;
        5'd1:    vector_of = 16'h0043;
        5'd2:    vector_of = 16'h0053;
        5'd3:    vector_of = 16'h000b;
        5'd4:    vector_of = 16'h0033;
        5'd5:    vector_of = 16'h005b;
        5'd6:    vector_of = 16'h0013;
        5'd7:    vector_of = 16'h003b;
        5'd8:    vector_of = 16'h001b;
        5'd9:    vector_of = 16'h0023;
        5'd10:   vector_of = 16'h0073;
        5'd11:   vector_of = 16'h004b;
        5'd12:   vector_of = 16'h002b;
        5'd13:   vector_of = 16'h0063;
        5'd14:   vector_of = 16'h006b;
        5'd15:   vector_of = 16'h007b;
        5'd16:   vector_of = 16'h0083;
        5'd17:   vector_of = 16'h008b;
        default: vector_of = 16'h0000;
      endcase
    end
  endfunction

  // ****************************************
  // In-service record and call sequence
  // ****************************************
  reg [3:0] next_in_service;

  always @* begin
    next_in_service = in_service;
    if (reti) begin
      // Drop only the innermost level, the outer handler resumes
      next_in_service[cur_lvl] = 1'b0;
    end
    if (take) begin
      next_in_service[win_lvl] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service <= 4'h0;
      call_cnt <= 3'h0;
      last_src <= 5'h00;
      irq_call <= 1'b0;
      irq_call_busy <= 1'b0;
      irq_vector <= 16'h0000;
      irq_level <= 2'h0;
      wake_request <= 1'b0;
    end else if (ce) begin
      in_service <= next_in_service;
      irq_call <= take;
      wake_request <= |(req & enable & wake_mask);
      if (take) begin
        call_cnt <= `IPC_CALL_CYCLES;
        irq_call_busy <= 1'b1;
        irq_vector <= vector_of(win_src);
        irq_level <= win_lvl;
        last_src <= win_src;
      end else if (call_cnt != 3'h0) begin
        call_cnt <= call_cnt - 3'h1;
        irq_call_busy <= (call_cnt != 3'h1);
      end
    end
  end

  // ****************************************
  // Request flags
  // ****************************************
  wire wr_flags = wr && paddr == `IPC_ADDR_FLAGS;
  wire wr_pins = wr && paddr == `IPC_ADDR_PIN_FLAGS;
  wire enter0 = take && win_src == 5'd0;
  wire enter1 = take && win_src == 5'd6;

  // Hardware set is checked before any clear so it is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external0_request_flag <= 1'b0;
      external1_request_flag <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      timer2_event_flag <= 1'b0;
      timer3_overflow_flag <= 1'b0;
      pin_channel_flag <= 8'h00;
      ext0_pin_q <= 1'b1;
      ext1_pin_q <= 1'b1;
      pin_in_q <= 8'h00;
    end else if (ce) begin
      ext0_pin_q <= ext0_pin_n;
      ext1_pin_q <= ext1_pin_n;
      pin_in_q <= pin_channel_in;
      if (!it0_edge) begin
        external0_request_flag <= ~ext0_pin_n;
      end else if (ext0_fall) begin
        external0_request_flag <= 1'b1;
      end else if (enter0) begin
        external0_request_flag <= 1'b0;
      end else if (wr_flags) begin
        external0_request_flag <= pwdata[0];
      end
      if (!it1_edge) begin
        external1_request_flag <= ~ext1_pin_n;
      end else if (ext1_fall) begin
        external1_request_flag <= 1'b1;
      end else if (enter1) begin
        external1_request_flag <= 1'b0;
      end else if (wr_flags) begin
        external1_request_flag <= pwdata[1];
      end
      if (timer0_overflow_set) begin
        timer0_overflow_flag <= 1'b1;
      end else if (take && win_src == 5'd3) begin
        timer0_overflow_flag <= 1'b0;
      end else if (wr_flags) begin
        timer0_overflow_flag <= pwdata[2];
      end
      if (timer1_overflow_set) begin
        timer1_overflow_flag <= 1'b1;
      end else if (take && win_src == 5'd8) begin
        timer1_overflow_flag <= 1'b0;
      end else if (wr_flags) begin
        timer1_overflow_flag <= pwdata[3];
      end
      if (timer2_event_set) begin
        timer2_event_flag <= 1'b1;
      end else if (wr_flags) begin
        timer2_event_flag <= pwdata[4];
      end
      if (timer3_overflow_set) begin
        timer3_overflow_flag <= 1'b1;
      end else if (take && win_src == 5'd16) begin
        timer3_overflow_flag <= 1'b0;
      end else if (wr_flags) begin
        timer3_overflow_flag <= pwdata[5];
      end
      for (j = 0; j < 8; j = j + 1) begin
        if (pin_level_mode[j]) begin
          pin_channel_flag[j] <= pin_channel_in[j];
        end else if (pin_channel_in[j] && !pin_in_q[j]) begin
          pin_channel_flag[j] <= 1'b1;
        end else if (wr_pins) begin
          pin_channel_flag[j] <= pwdata[j];
        end
      end
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  reg [31:0] rd_mux;
  reg        rd_hit;

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `IPC_ADDR_EXT_ENABLE_ONE:
        rd_mux = {29'h0, extended_interrupt_enable_one[2:0]};
      `IPC_ADDR_PRIO_HIGH: rd_mux = {25'h0, interrupt_priority_high_bits[6:0]};
      `IPC_ADDR_PRIO_LOW:  rd_mux = {25'h0, interrupt_priority_low_bits[6:0]};
      `IPC_ADDR_SRC_ENABLE: rd_mux = src_enable;
      `IPC_ADDR_EXT_PRIO:   rd_mux = ext_prio;
      `IPC_ADDR_TRIGGER:    rd_mux = {16'h0, trigger_cfg};
      `IPC_ADDR_FLAGS: rd_mux = {26'h0, timer3_overflow_flag,
        timer2_event_flag, timer1_overflow_flag, timer0_overflow_flag,
        external1_request_flag, external0_request_flag};
      `IPC_ADDR_PIN_FLAGS: rd_mux = {24'h0, pin_channel_flag};
      `IPC_ADDR_STATUS: rd_mux = {last_src[4], 5'h00, pending,
        last_src[3:0], in_service};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `IPC_REG32_RESET;
      extended_interrupt_enable_one <= `IPC_REG8_RESET;
      interrupt_priority_high_bits <= `IPC_REG8_RESET;
      interrupt_priority_low_bits <= `IPC_REG8_RESET;
      src_enable <= `IPC_REG32_RESET;
      ext_prio <= `IPC_REG32_RESET;
      trigger_cfg <= 16'h0000;
    end else if (ce) begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr <= ~rd_hit;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
        pslverr <= 1'b0;
      end
      if (wr && rd_hit) begin
        case (paddr)
          `IPC_ADDR_EXT_ENABLE_ONE: extended_interrupt_enable_one <=
            {5'h0, pwdata[2:0]};
          `IPC_ADDR_PRIO_HIGH:
            interrupt_priority_high_bits <= {1'b0, pwdata[6:0]};
          `IPC_ADDR_PRIO_LOW:
            interrupt_priority_low_bits <= {1'b0, pwdata[6:0]};
          `IPC_ADDR_SRC_ENABLE:
            src_enable <= {pwdata[31], 16'h0, pwdata[14:0]};
          `IPC_ADDR_EXT_PRIO:
            ext_prio <= {5'h0, pwdata[26:16], 5'h0, pwdata[10:0]};
          `IPC_ADDR_TRIGGER: trigger_cfg <= {pwdata[15:8], 6'h0, pwdata[1:0]};
          default: trigger_cfg <= trigger_cfg;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- ipc_core_model.sv
// Purpose: Behavioural core that polls and returns from handlers
// Assumes: One pclk domain, asynchronous active-low reset
// Notes:   slow polls every other cycle, like multi-cycle opcodes
`timescale 1ns/1ps
`default_nettype none
module ipc_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic ret_cmd,
  input  wire logic irq_call,
  input  wire logic irq_call_busy,
  output var  logic poll_ok,
  output var  logic reti
);
  // ****************
  // Instruction ends
  // ****************
  // No boundary while the hardware call stacks the return address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_ok <= 1'b0;
      reti    <= 1'b0;
    end else begin
      poll_ok <= !(irq_call || irq_call_busy) && (!slow || !poll_ok);
      reti    <= ret_cmd;
    end
  end
endmodule
`default_nettype wire

//--- ipc_checker.sv
// Purpose: Port-level assertions for the priority controller
// Assumes: ce drops only while no call is under way
// Notes:   Nesting is mirrored from calls and returns
`timescale 1ns/1ps
`default_nettype none
module ipc_checker #(
  parameter NSRC = 18
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        poll_ok,
  input wire logic        reti,
  input wire logic        irq_call,
  input wire logic        irq_call_busy,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0]  irq_level
);
  logic [2:0] depth;
  logic [1:0] stk [0:3];
  logic [1:0] top;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // Nesting mirror
  // ****************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth <= 3'h0;
    end else if (ce && irq_call) begin
      stk[depth[1:0]] <= irq_level;
      depth <= depth + 3'h1;
    end else if (ce && reti && depth != 3'h0) begin
      depth <= depth - 3'h1;
    end
  end
  assign top = stk[depth[1:0] - 2'h1];
  busy_len_a: assert property (irq_call |->
    irq_call_busy [*4] ##1 !irq_call_busy) else $error("busy length");
  call_pulse_a: assert property (irq_call |=> !irq_call)
    else $error("call not one cycle");
  vec_range_a: assert property (irq_call |->
    irq_vector[2:0] == 3'h3 && irq_vector <= 16'h008b)
    else $error("vector off grid");
  vec_hold_a: assert property (!irq_call |->
    $stable(irq_vector) && $stable(irq_level)) else $error("vector moved");
  reti_block_a: assert property (reti |=> !irq_call)
    else $error("call in return cycle");
  poll_block_a: assert property (!poll_ok |=> !irq_call)
    else $error("call without poll");
  idle_low_a: assert property (irq_call && irq_level == 2'h0
    |-> depth == 3'h0) else $error("lowest level nested");
  preempt_a: assert property (irq_call && depth != 3'h0
    |-> irq_level > top) else $error("preempt not higher");
  setup_ready_a: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind ipc_interrupt_priority_controller ipc_checker #(.NSRC(NSRC)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .poll_ok(poll_ok), .reti(reti),
  .irq_call(irq_call), .irq_call_busy(irq_call_busy),
  .irq_vector(irq_vector), .irq_level(irq_level)
);
`default_nettype wire

//--- tb.sv
// Purpose: Register, nesting and ordering tests of the controller
// Assumes: Zero-wait APB, core model drives poll and return
// Notes:   Requests packed by natural index in lv
`include "ipc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, slow, ret_cmd, rx1;
  logic        pready, pslverr, rerr, poll_ok, reti, ce;
  logic        irq_call, irq_call_busy, wake_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] irq_vector;
  logic [1:0]  irq_level;
  logic [17:0] lv;
  logic [3:0]  tp;
  int          err_total, cmp_count, cyc;
  int          vk [18] = '{0,8,10,1,6,11,2,7,3,4,14,9,5,12,13,15,16,17};
  logic [11:0] ra [3] = '{`IPC_ADDR_EXT_ENABLE_ONE, `IPC_ADDR_PRIO_HIGH,
                          `IPC_ADDR_PRIO_LOW};
  logic [31:0] rm [3] = '{32'h00000007, 32'h0000007f, 32'h0000007f};
  localparam logic [17:0] wake_set = 18'h200c7;
  ipc_interrupt_priority_controller u_ipc_interrupt_priority_controller (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext0_pin_n(~lv[0]), .ext1_pin_n(~lv[6]),
    .timer0_overflow_set(tp[0]), .timer1_overflow_set(tp[1]),
    .timer2_event_set(tp[2]), .timer3_overflow_set(tp[3]),
    .pin_channel_in({7'h00, lv[7]}), .brownout_req(lv[1]),
    .watchdog_req(lv[2]), .i2c_req(lv[4]), .adc_req(lv[5]),
    .serial0_req(lv[9]), .fault_brake_req(lv[10]), .spi_req(lv[11]),
    .capture_req(lv[13]), .pwm_req(lv[14]), .serial1_transmit_flag(lv[15]),
    .serial1_receive_flag(rx1), .wakeup_timer_flag(lv[17]), .poll_ok,
    .reti, .irq_call, .irq_call_busy, .irq_vector, .irq_level, .wake_request
  );
  ipc_core_model u_ipc_core_model (
    .pclk, .presetn, .slow, .ret_cmd, .irq_call, .irq_call_busy, .poll_ok,
    .reti
  );
  // ****************
  // Tasks
  // ****************
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 20)
      chk("apb_wait", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task ex(input logic [15:0] v, input logic [1:0] l);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_call !== 1'b1 && n < 60);
    chk("vector", 32'(v), 32'(irq_vector));
    chk("level", 32'(l), 32'(irq_level));
  endtask
  // Fixed waits span the four busy cycles of the call
  task ret;
    repeat (6) @(posedge pclk);
    ret_cmd <= 1'b1;
    @(posedge pclk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task nocall(input int c);
    logic s;
    s = 1'b0;
    repeat (c) begin
      @(posedge pclk);
      s = s | (irq_call === 1'b1);
    end
    chk("no_call", 32'h0, 32'(s));
  endtask
  task pulse(input logic [3:0] m);
    tp <= m;
    @(posedge pclk);
    tp <= 4'h0;
  endtask
  // ****************
  // Stimulus
  // ****************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, slow, ret_cmd, rx1} = 7'h00;
    ce = 1'b1;
    {paddr, pwdata, lv, tp} = 66'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rc("reg_reset", ra[i], 32'h0);
      apb(1'b1, ra[i], 32'hffffffff);
      rc("reg_rw", ra[i], rm[i]);
    end
    apb(1'b0, 12'h3fc, 32'h0);
    chk("unmapped_err", 32'h1, 32'(rerr));
    $display("test registers done");
    apb(1'b1, `IPC_ADDR_PRIO_HIGH, 32'h0);
    apb(1'b1, `IPC_ADDR_PRIO_LOW, 32'h0);
    apb(1'b1, `IPC_ADDR_TRIGGER, 32'h00000100);
    apb(1'b1, `IPC_ADDR_SRC_ENABLE, 32'h00007fff);
    pulse(4'hf);
    lv <= ~wake_set;
    nocall(8);
    chk("wake_off", 32'h0, 32'(wake_request));
    for (int i = 0; i < 18; i++) begin
      if (wake_set[i]) begin
        lv[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("wake_on", 32'h1, 32'(wake_request));
        lv[i] <= 1'b0;
      end
    end
    @(posedge pclk);
    lv <= 18'h3ffff;
    apb(1'b1, `IPC_ADDR_SRC_ENABLE, 32'h80007fff);
    for (int i = 0; i < 18; i++) begin
      ex(16'h0003 + 16'(vk[i] * 8), 2'h0);
      rc("flags", `IPC_ADDR_FLAGS, {26'h0, i < 16, i <= 12, i < 8, i < 3,
         i <= 6, i <= 0});
      lv[i] <= 1'b0;
      if (i == 12)
        apb(1'b1, `IPC_ADDR_FLAGS, 32'h00000020);
      ret;
    end
    $display("test natural order done");
    slow <= 1'b1;
    apb(1'b1, `IPC_ADDR_PRIO_LOW, 32'h00000048);
    apb(1'b1, `IPC_ADDR_PRIO_HIGH, 32'h00000060);
    lv[0] <= 1'b1;
    ex(16'h0003, 2'h0);
    lv[9] <= 1'b1;
    pulse(4'h2);
    ex(16'h001b, 2'h1);
    lv[1] <= 1'b1;
    ex(16'h0043, 2'h2);
    lv[5] <= 1'b1;
    ex(16'h005b, 2'h3);
    lv[5] <= 1'b0;
    ret;
    nocall(10);
    lv[1] <= 1'b0;
    ret;
    nocall(10);
    ret;
    nocall(10);
    lv[0] <= 1'b0;
    ret;
    ex(16'h0023, 2'h0);
    lv[9] <= 1'b0;
    ret;
    lv[0] <= 1'b1;
    pulse(4'h2);
    ex(16'h001b, 2'h1);
    ret;
    ex(16'h0003, 2'h0);
    lv[0] <= 1'b0;
    ret;
    $display("test nesting done");
    rx1 <= 1'b1;
    ex(16'h007b, 2'h0);
    rx1 <= 1'b0;
    ret;
    apb(1'b1, `IPC_ADDR_TRIGGER, 32'h00000001);
    lv[0] <= 1'b1;
    ex(16'h0003, 2'h0);
    rc("edge_flag", `IPC_ADDR_FLAGS, 32'h0);
    lv[0] <= 1'b0;
    ret;
    // Timer 2 set pulse lands on a frozen edge and must be lost
    ce <= 1'b0;
    pulse(4'h4);
    ce <= 1'b1;
    rc("ce_freeze", `IPC_ADDR_FLAGS, 32'h0);
    $display("test flags done");
    wrap_up;
  end
endmodule
`default_nettype wire
